//--- rtl/gdcd_device.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
module gdcd_device
(
   // system
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // two-wire link
   gdcd_link_if.device                   link,
   // board pins
   input  wire logic                     addr_strap,
   input  wire logic                     latch_hold_pin,
   // converter drive
   output logic [15:0][9:0]              channel_level,
   output logic                          otp_locked
);

   typedef enum logic [2:0]
   {
      ST_IDLE, ST_DEVADDR, ST_CMD, ST_DATA_HI, ST_DATA_LO, ST_READ, ST_ACQ, ST_IGNORE
   } gdcd_dev_state_t;

   localparam int LW = gdcd_pkg::LEVEL_W;

   logic [1:0]       scl_sync;
   logic [1:0]       sda_sync;
   logic [1:0]       ld_sync;
   logic [1:0]       a0_sync;
   logic             scl_d;
   logic             sda_d;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_cond;
   logic             stop_cond;
   gdcd_dev_state_t  state;
   logic             gcall;
   logic [3:0]       bit_cnt;
   logic [7:0]       rx_sh;
   logic [7:0]       tx_sh;
   logic             sda_low;
   logic [4:0]       ptr;
   logic             sets_done;
   logic [7:0]       hi_byte;
   logic             send_lo;
   logic             acq_sel_all;
   logic             commit;
   logic             commit_single;
   logic [4:0]       commit_addr;
   logic [15:0]      commit_word;
   logic             acq_all;
   logic             acq_one;
   logic             gc_reset;
   logic [15:0]      rd_word;
   logic [7:0]       next_tx;
   logic [LW-1:0]    hold [gdcd_pkg::NUM_SLOTS];
   logic [LW-1:0]    dac  [gdcd_pkg::NUM_SLOTS];
   logic [LW-1:0]    otp  [gdcd_pkg::NUM_SLOTS];
   logic [LW-1:0]    otp_new;
   logic             lock;

   // ---------------------------------------------------
   // pin synchronisers and bus conditions
   // ---------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         ld_sync  <= 2'h0;
         a0_sync  <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], link.scl};
         sda_sync <= {sda_sync[0], link.sda};
         ld_sync  <= {ld_sync[0], latch_hold_pin};
         a0_sync  <= {a0_sync[0], addr_strap};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end

   assign scl_rise   = scl_sync[1] && !scl_d;
   assign scl_fall   = !scl_sync[1] && scl_d;
   assign start_cond = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
   assign stop_cond  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

   // open drain: only ever pulls low
   assign link.dev_sda_out = 1'b0;
   assign link.dev_sda_oe  = sda_low;

   // channel read data always shows the converter side; the lock address reads the lock flag
   always_comb
   begin
      rd_word = 16'h0000;
      if (gdcd_pkg::addr_live(ptr))
         rd_word = {6'h00, dac[ptr]}; // R15
      else if (ptr == gdcd_pkg::ADDR_LOCK)
         rd_word = {15'h0000, lock};
      next_tx = send_lo ? rd_word[7:0] : rd_word[15:8]; // R17
   end

   // ---------------------------------------------------
   // byte engine
   // ---------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state         <= ST_IDLE;
         gcall         <= 1'b0;
         bit_cnt       <= 4'h0;
         rx_sh         <= 8'h00;
         tx_sh         <= 8'h00;
         sda_low       <= 1'b0;
         ptr           <= 5'h00;
         sets_done     <= 1'b0;
         hi_byte       <= 8'h00;
         send_lo       <= 1'b0;
         acq_sel_all   <= 1'b0;
         commit        <= 1'b0;
         commit_single <= 1'b0;
         commit_addr   <= 5'h00;
         commit_word   <= 16'h0000;
         acq_all       <= 1'b0;
         acq_one       <= 1'b0;
         gc_reset      <= 1'b0;
      end
      else
      begin
         commit   <= 1'b0;
         acq_all  <= 1'b0;
         acq_one  <= 1'b0;
         gc_reset <= 1'b0;
         if (start_cond || stop_cond)
         begin
            // a half-received data set simply never commits
            state   <= start_cond ? ST_DEVADDR : ST_IDLE; // R14 R20 R24
            // the scl fall that closes a start is not a data bit
            bit_cnt <= start_cond ? 4'hf : 4'h0;
            sda_low <= 1'b0;
            if (stop_cond && state == ST_ACQ)
            begin
               acq_all <= acq_sel_all; // R1
               acq_one <= !acq_sel_all; // R2
            end
         end
         else if (scl_rise)
         begin
            if (bit_cnt < 4'h8)
               rx_sh <= {rx_sh[6:0], sda_sync[1]};
            else if (state == ST_READ && sda_sync[1])
               state <= ST_IGNORE; // R18 R20
         end
         else if (scl_fall && state != ST_IDLE)
         begin
            if (bit_cnt == 4'h7)
            begin
               bit_cnt <= 4'h8;
               sda_low <= 1'b0;
               unique case (state)
                  ST_DEVADDR:
                  begin
                     gcall   <= 1'b0;
                     send_lo <= 1'b0;
                     if (rx_sh[7:1] == {gdcd_pkg::DEV_ADDR_BASE, a0_sync[1]})
                     begin
                        sda_low <= 1'b1;
                        state   <= rx_sh[0] ? ST_READ : ST_CMD; // R5
                     end
                     else if (rx_sh == gdcd_pkg::GCALL_ADDR)
                     begin
                        sda_low <= 1'b1;
                        gcall   <= 1'b1;
                        state   <= ST_DATA_HI;
                     end
                     else
                        state <= ST_IGNORE;
                  end
                  ST_CMD:
                  begin
                     if (gdcd_pkg::addr_valid(rx_sh[4:0]) && // R3
                         (rx_sh[7:5] == gdcd_pkg::CMD_REG ||
                          rx_sh[7:5] == gdcd_pkg::CMD_ACQ_ALL ||
                          rx_sh[7:5] == gdcd_pkg::CMD_ACQ_ONE))
                     begin
                        sda_low     <= 1'b1;
                        ptr         <= rx_sh[4:0];
                        sets_done   <= 1'b0;
                        acq_sel_all <= (rx_sh[7:5] == gdcd_pkg::CMD_ACQ_ALL);
                        state       <= (rx_sh[7:5] == gdcd_pkg::CMD_REG) ? ST_DATA_HI : ST_ACQ;
                     end
                     else
                        state <= ST_IGNORE; // R24
                  end
                  ST_DATA_HI:
                  begin
                     if (gcall)
                     begin
                        sda_low  <= (rx_sh == gdcd_pkg::GCALL_RESET);
                        gc_reset <= (rx_sh == gdcd_pkg::GCALL_RESET);
                        state    <= ST_IGNORE;
                     end
                     else
                     begin
                        sda_low <= 1'b1; // R13
                        hi_byte <= rx_sh;
                        state   <= ST_DATA_LO;
                     end
                  end
                  ST_DATA_LO:
                  begin
                     sda_low       <= 1'b1; // R13
                     commit        <= 1'b1; // R8
                     commit_addr   <= ptr;
                     commit_word   <= {hi_byte, rx_sh}; // R7
                     commit_single <= !sets_done; // R12
                     sets_done     <= 1'b1;
                     if (ptr != 5'h1f)
                        ptr <= ptr + 5'h01; // R10
                     state <= ST_DATA_HI;
                  end
                  ST_READ:
                     sda_low <= 1'b0;
                  default:
                     state <= ST_IGNORE;
               endcase
            end
            else if (bit_cnt == 4'h8)
            begin
               bit_cnt <= 4'h0;
               sda_low <= 1'b0;
               if (state == ST_READ)
               begin
                  tx_sh   <= next_tx;
                  sda_low <= !next_tx[7];
                  send_lo <= !send_lo;
                  if (send_lo && ptr != 5'h1f)
                     ptr <= ptr + 5'h01; // R19
               end
            end
            else
            begin
               bit_cnt <= bit_cnt + 4'h1;
               if (state == ST_READ)
               begin
                  tx_sh   <= {tx_sh[6:0], 1'b0};
                  sda_low <= !tx_sh[6];
               end
            end
         end
      end
   end

   // ---------------------------------------------------
   // holding, converter and otp storage
   // ---------------------------------------------------
   // otp bits can only be set, never cleared
   assign otp_new = otp[commit_addr] | commit_word[LW-1:0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < gdcd_pkg::NUM_SLOTS; i++)
         begin
            hold[i] <= gdcd_pkg::LEVEL_RESET;
            dac[i]  <= gdcd_pkg::LEVEL_RESET;
            otp[i]  <= gdcd_pkg::LEVEL_RESET;
         end
         lock <= 1'b0;
      end
      else if (gc_reset || acq_all)
      begin
         for (int i = 0; i < gdcd_pkg::NUM_SLOTS; i++)
         begin
            hold[i] <= otp[i]; // R1
            dac[i]  <= otp[i];
         end
      end
      else if (acq_one && gdcd_pkg::addr_live(ptr))
      begin
         hold[ptr] <= otp[ptr]; // R2
         dac[ptr]  <= otp[ptr];
      end
      else if (commit && commit_addr == gdcd_pkg::ADDR_LOCK)
      begin
         if (commit_single && commit_word[0])
            lock <= 1'b1; // R9 R12
      end
      else if (commit && gdcd_pkg::addr_live(commit_addr)) // R4 R11
      begin
         if (commit_word[15:14] == gdcd_pkg::ROUTE_OTP) // R21
         begin
            if (!lock) // R23
            begin
               otp[commit_addr]  <= otp_new;
               hold[commit_addr] <= otp_new;
               dac[commit_addr]  <= otp_new;
            end
         end
         else if (!ld_sync[1])
         begin
            hold[commit_addr] <= commit_word[LW-1:0];
            dac[commit_addr]  <= commit_word[LW-1:0];
         end
         else if (commit_word[15:14] == gdcd_pkg::SOFT_LATCH)
         begin
            hold[commit_addr] <= commit_word[LW-1:0];
            for (int i = 0; i < gdcd_pkg::NUM_SLOTS; i++)
               dac[i] <= (5'(i) == commit_addr) ? commit_word[LW-1:0] : hold[i]; // R22
         end
         else
            hold[commit_addr] <= commit_word[LW-1:0];
      end
      else if (!ld_sync[1])
      begin
         // latch released: converters track the holding registers
         for (int i = 0; i < gdcd_pkg::NUM_SLOTS; i++)
            dac[i] <= hold[i];
      end
   end

   // ---------------------------------------------------
   // outputs
   // ---------------------------------------------------
   always_comb
   begin
      for (int i = 0; i <= int'(gdcd_pkg::ADDR_LAST_GAMMA); i++)
         channel_level[i] = dac[i]; // R4
      channel_level[14] = dac[gdcd_pkg::ADDR_COMMON_VOLTAGE_LEVEL_1];
      channel_level[15] = dac[gdcd_pkg::ADDR_COMMON_VOLTAGE_LEVEL_2];
   end

   assign otp_locked = lock;

endmodule

//--- rtl/gdcd_host.sv
`timescale 1ns/1ps
module gdcd_host
#(
   parameter int QUARTER_CYC = gdcd_pkg::LINK_QUARTER_CYC
)
(
   // system
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic [7:0]       paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   // two-wire link
   gdcd_link_if.host             link
);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} gdcd_host_state_t;

   gdcd_host_state_t  state;
   logic [1:0]        sda_sync;
   logic [15:0]       q_cnt;
   logic              tick;
   logic [1:0]        qph;
   logic [3:0]        bit_idx;
   logic [7:0]        sh;
   logic [7:0]        tx_data;
   logic [7:0]        rx_data;
   logic              want_stop;
   logic              op_byte;
   logic              op_write;
   logic              send_nack;
   logic              nack_seen;
   logic              scl_low;
   logic              sda_low;
   logic              mapped;
   logic              launch;

   // ---------------------------------------------------
   // apb access
   // ---------------------------------------------------
   assign pready  = 1'b1;
   assign mapped  = (paddr == gdcd_pkg::HOST_CMD_OFS) || (paddr == gdcd_pkg::HOST_TX_OFS) ||
                    (paddr == gdcd_pkg::HOST_RX_OFS) || (paddr == gdcd_pkg::HOST_STAT_OFS);
   assign pslverr = psel && penable && !mapped;
   // commands written while busy are dropped; poll status first
   assign launch  = psel && penable && pwrite && paddr == gdcd_pkg::HOST_CMD_OFS &&
                    state == H_IDLE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         tx_data <= 8'h00;
      end
      else
      begin
         if (psel && !penable)
            unique case (paddr)
               gdcd_pkg::HOST_TX_OFS:   prdata <= {24'h000000, tx_data};
               gdcd_pkg::HOST_RX_OFS:   prdata <= {24'h000000, rx_data};
               gdcd_pkg::HOST_STAT_OFS: prdata <= {30'h0000_0000, nack_seen, state != H_IDLE};
               default:                 prdata <= 32'h0000_0000;
            endcase
         if (psel && penable && pwrite && paddr == gdcd_pkg::HOST_TX_OFS)
            tx_data <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------
   // quarter-bit divider and sda sync
   // ---------------------------------------------------
   assign tick = (q_cnt == 16'(QUARTER_CYC - 1));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q_cnt    <= 16'h0000;
         sda_sync <= 2'h3;
      end
      else
      begin
         sda_sync <= {sda_sync[0], link.sda};
         q_cnt    <= (launch || tick || state == H_IDLE) ? 16'h0000 : q_cnt + 16'h0001;
      end
   end

   assign link.scl_out      = 1'b0;
   assign link.scl_oe       = scl_low;
   assign link.host_sda_out = 1'b0;
   assign link.host_sda_oe  = sda_low;

   // ---------------------------------------------------
   // bit sequencer
   // ---------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state     <= H_IDLE;
         qph       <= 2'h0;
         bit_idx   <= 4'h0;
         sh        <= 8'h00;
         rx_data   <= 8'h00;
         want_stop <= 1'b0;
         op_byte   <= 1'b0;
         op_write  <= 1'b0;
         send_nack <= 1'b0;
         nack_seen <= 1'b0;
         scl_low   <= 1'b0;
         sda_low   <= 1'b0;
      end
      else if (launch)
      begin
         want_stop <= pwdata[gdcd_pkg::CMD_STOP_BIT];
         op_byte   <= pwdata[gdcd_pkg::CMD_WRITE_BIT] || pwdata[gdcd_pkg::CMD_READ_BIT];
         op_write  <= pwdata[gdcd_pkg::CMD_WRITE_BIT];
         send_nack <= pwdata[gdcd_pkg::CMD_NACK_BIT];
         sh        <= tx_data;
         qph       <= 2'h0;
         bit_idx   <= 4'h0;
         if (pwdata[gdcd_pkg::CMD_START_BIT])
            state <= H_START;
         else if (pwdata[gdcd_pkg::CMD_WRITE_BIT] || pwdata[gdcd_pkg::CMD_READ_BIT])
            state <= H_BIT;
         else if (pwdata[gdcd_pkg::CMD_STOP_BIT])
            state <= H_STOP;
      end
      else if (tick)
      begin
         qph <= qph + 2'h1;
         unique case (state)
            H_START:
               unique case (qph)
                  2'h0:
                  begin
                     scl_low <= 1'b1;
                     sda_low <= 1'b0;
                  end
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b1; // R16
                  2'h3:
                  begin
                     scl_low <= 1'b1;
                     state   <= op_byte ? H_BIT : (want_stop ? H_STOP : H_IDLE);
                  end
               endcase
            H_BIT:
               unique case (qph)
                  2'h0:
                  begin
                     scl_low <= 1'b1;
                     if (bit_idx < 4'h8)
                        sda_low <= op_write && !sh[7]; // R5 R6 R7
                     else
                        sda_low <= !op_write && !send_nack; // R18 R19
                  end
                  2'h1: scl_low <= 1'b0;
                  2'h2:
                  begin
                     if (bit_idx < 4'h8)
                        sh <= {sh[6:0], sda_sync[1]};
                     else
                        nack_seen <= op_write && sda_sync[1]; // R13
                  end
                  2'h3:
                  begin
                     scl_low <= 1'b1;
                     bit_idx <= bit_idx + 4'h1;
                     if (bit_idx == 4'h8)
                     begin
                        if (!op_write)
                           rx_data <= sh; // R17
                        state <= want_stop ? H_STOP : H_IDLE;
                     end
                  end
               endcase
            H_STOP:
               unique case (qph)
                  2'h0:
                  begin
                     scl_low <= 1'b1;
                     sda_low <= 1'b1;
                  end
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b0; // R1 R2
                  2'h3: state <= H_IDLE;
               endcase
            H_IDLE: qph <= 2'h0;
         endcase
      end
   end

endmodule

//--- rtl/gdcd_link_if.sv
`timescale 1ns/1ps
interface gdcd_link_if;
   logic scl_out;
   logic scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // open-drain wired-and with pull-ups
   assign scl = !(scl_oe && !scl_out);
   assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

   modport host   (output scl_out, scl_oe, host_sda_out, host_sda_oe, input scl, sda);
   modport device (output dev_sda_out, dev_sda_oe, input scl, sda);
endinterface

//--- rtl/gdcd_pkg.sv
// Functional notes
// R1: code 100 then STOP reloads all from OTP
// R2: code 010 reloads only addressed channel from OTP
// R3: acknowledge only addresses 0-13, 18, 19, 20
// R4: address map: gammas, two common voltages, lock
// R5: direction bit low writes, high reads
// R6: master sends command byte top bits 000
// R7: two data bytes, MSB first; 01 means OTP
// R8: commit only after second data byte
// R9: lock address uses data bit zero only
// R10: pointer advances after each complete data set
// R11: twenty sets; sets 15-18 dropped, 19-20 common
// R12: multi-write never reaches lock flag
// R13: device acknowledges every written data byte
// R14: partial data set discarded on early end
// R15: read returns converter value, not holding value
// R16: read: write address, restart, read address
// R17: read returns MSB first, then LSB
// R18: single read ends by NACK or STOP
// R19: acknowledged reads continue with next channel
// R20: read abandoned on STOP, START or NACK
// R21: top bits 01 steer word to OTP
// R22: latch held: bits 15:14 = 10 update all
// R23: lock set refuses all OTP programming
// R24: unacknowledged address ignored until START/STOP
package gdcd_pkg;

   // ---------------------------------------------------
   // link addressing and command codes
   // ---------------------------------------------------
   localparam logic [5:0] DEV_ADDR_BASE   = 6'h3a;
   localparam logic [7:0] GCALL_ADDR      = 8'h00;
   localparam logic [7:0] GCALL_RESET     = 8'h06;
   localparam logic [2:0] CMD_REG         = 3'h0;
   localparam logic [2:0] CMD_ACQ_ALL     = 3'h4;
   localparam logic [2:0] CMD_ACQ_ONE     = 3'h2;
   localparam logic [4:0] ADDR_LAST_GAMMA = 5'h0d;
   localparam logic [4:0] ADDR_COMMON_VOLTAGE_LEVEL_1      = 5'h12;
   localparam logic [4:0] ADDR_COMMON_VOLTAGE_LEVEL_2      = 5'h13;
   localparam logic [4:0] ADDR_LOCK       = 5'h14;
   localparam logic [1:0] ROUTE_OTP       = 2'h1;
   localparam logic [1:0] SOFT_LATCH      = 2'h2;

   // ---------------------------------------------------
   // storage shape and reset values
   // ---------------------------------------------------
   localparam int          NUM_SLOTS    = 20;
   localparam int          NUM_CHANNELS = 16;
   localparam int          LEVEL_W      = 10;
   localparam logic [9:0]  LEVEL_RESET  = 10'h000;

   // ---------------------------------------------------
   // controller registers (apb byte offsets, fields)
   // ---------------------------------------------------
   localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
   localparam logic [7:0] HOST_TX_OFS   = 8'h04;
   localparam logic [7:0] HOST_RX_OFS   = 8'h08;
   localparam logic [7:0] HOST_STAT_OFS = 8'h0c;
   localparam int         CMD_START_BIT = 0;
   localparam int         CMD_STOP_BIT  = 1;
   localparam int         CMD_WRITE_BIT = 2;
   localparam int         CMD_READ_BIT  = 3;
   localparam int         CMD_NACK_BIT  = 4;

   // ---------------------------------------------------
   // timing
   // ---------------------------------------------------
   localparam int CLK_PERIOD_NS    = 25;
   localparam int LINK_QUARTER_NS  = 100;
   localparam int LINK_QUARTER_CYC = LINK_QUARTER_NS / CLK_PERIOD_NS;

   function automatic logic addr_live(input logic [4:0] a);
      return (a <= ADDR_LAST_GAMMA) || (a == ADDR_COMMON_VOLTAGE_LEVEL_1) || (a == ADDR_COMMON_VOLTAGE_LEVEL_2);
   endfunction

   function automatic logic addr_valid(input logic [4:0] a);
      return addr_live(a) || (a == ADDR_LOCK);
   endfunction

endpackage

//--- testbench/gdcd_props.sv
`timescale 1ns/1ps
module gdcd_props
(
   // system and resolved link
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -----------------------------------------------
   // device timing on the wire
   // -----------------------------------------------
   chk_dev_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device sda moved while scl high");
   // sync latency means no reaction in the cycle after a fall
   chk_dev_lag: assert property ($fell(scl) |=> $stable(dev_sda_oe))
      else $error("device sda moved too soon");
   chk_dev_onset: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device drive began with scl high");
   chk_dev_release: assert property (dev_sda_oe |-> ##[1:400] !dev_sda_oe)
      else $error("device held sda too long");
   chk_stop_quiet: assert property (scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*4])
      else $error("device drove after stop");
   // -----------------------------------------------
   // host framing
   // -----------------------------------------------
   chk_scl_low: assert property ($fell(scl) |-> !scl [*4])
      else $error("scl low phase short");
   chk_scl_high: assert property ($rose(scl) |-> scl [*8])
      else $error("scl high phase short");
   chk_start_host: assert property (scl && $past(scl) && $fell(sda) |-> host_sda_oe)
      else $error("start not made by host");
   cov_ack: cover property (scl && dev_sda_oe);
   cov_start: cover property (scl && $fell(sda));
   cov_stop: cover property (scl && $rose(sda));
endmodule

//--- testbench/test_gamma_dac_command_decoder.sv
`timescale 1ns/1ps
module test_gamma_dac_command_decoder;
   logic             pclk, presetn, psel, penable, pwrite, pready, latch_hold_pin, otp_locked;
   logic [7:0]       paddr, a, q[$];
   logic [31:0]      pwdata, prdata, r;
   logic [15:0]      v, w;
   logic [23:0]      rows[4];
   logic [15:0][9:0] channel_level;
   int               mismatches, checks;
   gdcd_link_if link();
   gdcd_host i_gdcd_host(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(), .link(link));
   gdcd_device i_gdcd_device(.pclk(pclk), .presetn(presetn), .link(link), .addr_strap(1'b0),
      .latch_hold_pin(latch_hold_pin), .channel_level(channel_level), .otp_locked(otp_locked));
   gdcd_props i_gdcd_props(.pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
      .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));
   initial
   begin
      pclk = 0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] ad, input logic wr_en, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= ad;
      pwrite <= wr_en;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   // one byte per command, then poll busy
   task automatic op(input logic [4:0] c, input logic [7:0] b);
      apb(8'h04, 1, {24'h0, b});
      apb(8'h00, 1, {27'h0, c});
      r = 1;
      for (int n = 0; n < 200 && r[0] !== 1'b0; n++) apb(8'h0c, 0, 0);
      if (r[0] !== 1'b0) chk(r, 0);
   endtask
   task automatic wr(input logic [7:0] b[$]);
      op(5, 8'he8);
      foreach (b[i]) op(i == b.size() - 1 ? 5'd6 : 5'd4, b[i]);
   endtask
   task automatic rd(input logic [7:0] ad);
      op(5, 8'he8);
      op(4, ad);
      op(5, 8'he9);
      op(8, 0);
      apb(8'h08, 0, 0);
      v[15:8] = r[7:0];
      op(26, 0);
      apb(8'h08, 0, 0);
      v[7:0] = r[7:0];
   endtask
   initial
   begin
      #2_000_000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, latch_hold_pin} = '0;
      rows = '{24'h000155, 24'h0d02aa, 24'h1203ff, 24'h130201};
      repeat (10) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      chk(channel_level[0], 0);
      foreach (rows[i])
      begin
         a = rows[i][23:16];
         w = rows[i][15:0];
         wr('{a, w[15:8], w[7:0]});
         chk(channel_level[a < 14 ? a : a - 4], w[9:0]);
         rd(a);
         chk(v, {6'h0, w[9:0]});
         $display("row %0d done", i);
      end
      wr('{8'h0e, 8'h01, 8'h11});
      chk(r[1], 1);
      chk(channel_level[0], 10'h155);
      wr('{8'h00, 8'h03});
      chk(channel_level[0], 10'h155);
      q = '{8'h0c};
      for (int k = 0; k < 8; k++)
      begin
         q.push_back(8'h00);
         q.push_back(8'h40 + 8'(k));
      end
      wr(q);
      chk({channel_level[15], channel_level[14], channel_level[13], channel_level[12]},
          {10'h47, 10'h46, 10'h41, 10'h40});
      wr('{8'h13, 8'h00, 8'h01, 8'h00, 8'h01});
      chk(otp_locked, 0);
      wr('{8'h01, 8'h41, 8'h23});
      chk(channel_level[1], 10'h123);
      wr('{8'h01, 8'h00, 8'h05});
      wr('{8'h41});
      chk({channel_level[1], channel_level[0]}, {10'h123, 10'h155});
      wr('{8'h80});
      chk(channel_level[0], 0);
      $display("abort and acquire tests done");
      latch_hold_pin <= 1;
      wr('{8'h02, 8'h00, 8'h77});
      rd(8'h02);
      chk(v, 0);
      wr('{8'h03, 8'h80, 8'h11});
      chk({channel_level[3], channel_level[2]}, {10'h11, 10'h77});
      latch_hold_pin <= 0;
      wr('{8'h14, 8'h00, 8'h01});
      chk(otp_locked, 1);
      wr('{8'h04, 8'h43, 8'hff});
      wr('{8'h44});
      chk(channel_level[4], 0);
      $display("latch and lock tests done");
      complete_run();
   end
endmodule
